// >>> hdl/rapp_path.sv
`timescale 1ns/10ps
// Functional notes
// - current shifted -89 deg times voltage
// - low-pass keeps dc reactive per phase
// - combination select picks reactive sum formula
// - each term gated by line term enable
// - term enables also gate redirected active, not apparent terms
// - reactive bit: total reactive into line active
// - reactive bit: active goes to apparent acc
// - reactive bit: no apparent half-cycle accumulation
// - zero-crossing bits 4..6 select counted phases
// - same bits enable per-phase detection
// - cycle length from 16-bit count register
// - completion sets accumulation-complete flag
// - enabled flag drives interrupt low
// - reactive scaled by 1/9.546
// - uses corrected, filtered, shifted current
// - apparent is rms voltage times rms current
// - total apparent sums phase values
// - signed 12-bit apparent gain per phase
// - no apparent offset compensation
// - mode 0 star, 1 and 2 delta forms
// - redirected active summed ignoring sign
module rapp_path import rapp_pkg::*; #(
    parameter int ACC_W = 48
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic SAMPLE_VALID,
    input wire rapp_phase_type PH_A,
    input wire rapp_phase_type PH_B,
    input wire rapp_phase_type PH_C,
    input wire logic [2:0] ZX_IN,
    output logic [2:0] ZX_DET_EN,
    output logic IRQ_N,
    output logic IRQ_N_OE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic signed [47:0] smul(input logic signed [23:0] a,
                                                input logic signed [23:0] b);
        smul = a * b;
    endfunction

    function automatic logic signed [47:0] absv(input logic signed [47:0] a);
        absv = a[47] ? -a : a;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] wav_r;
    logic [7:0] pwrsum_r;
    logic [7:0] measurement_mode_reg_r;
    logic [15:0] hcyc_r;
    logic done_flag_r;
    logic done_en_r;
    logic [11:0] vagain_r [3];
    logic signed [47:0] q_lpf_r [3];
    logic signed [ACC_W-1:0] lae_acc_r;
    logic [ACC_W-1:0] lvae_acc_r;
    logic signed [ACC_W-1:0] lae_hold_r;
    logic [ACC_W-1:0] lvae_hold_r;
    logic signed [47:0] qtot_r;
    logic [47:0] stot_r;
    logic [15:0] zx_cnt_r;
    logic [31:0] prdata_r;

    logic wr;
    logic react_sel;
    logic [2:0] term_en;
    rapp_comb_type comb;
    logic signed [47:0] q_inst [3];
    logic signed [47:0] p_ph [3];
    logic [47:0] s_ph [3];
    logic signed [47:0] qtot_nxt;
    logic signed [47:0] ptot_abs;
    logic [47:0] stot_nxt;
    logic [1:0] zx_hits;
    logic cycle_end;

    assign wr = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign react_sel = wav_r[RAPP_WAV_REACT_BIT];
    assign term_en = pwrsum_r[RAPP_TERM_LSB +: 3];
    assign comb = rapp_comb_type'(pwrsum_r[RAPP_COMB_LSB +: 2]);
    assign ZX_DET_EN = measurement_mode_reg_r[RAPP_ZX_LSB +: 3];

    // ----------------------------------------------------------------
    // apb writes
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wav_r <= RAPP_WAV_RST;
            pwrsum_r <= RAPP_PWRSUM_RST;
            measurement_mode_reg_r <= RAPP_MEASUREMENT_MODE_REG_RST;
            hcyc_r <= RAPP_HCYC_RST;
            done_en_r <= 1'b0;
            for (int k = 0; k < 3; k++) begin
                vagain_r[k] <= RAPP_VAGAIN_RST;
            end
        end else if (wr) begin
            unique case (PADDR)
                RAPP_ADDR_WAVEFORM_MODE_CONTROL: wav_r <= PWDATA[7:0];
                RAPP_ADDR_PWRSUM: pwrsum_r <= PWDATA[7:0];
                RAPP_ADDR_MEASUREMENT_MODE_REG: measurement_mode_reg_r <= PWDATA[7:0];
                RAPP_ADDR_HCYC: hcyc_r <= PWDATA[15:0];
                RAPP_ADDR_IRQEN: done_en_r <= PWDATA[RAPP_FLAG_DONE_BIT];
                RAPP_ADDR_VAGAIN_A: vagain_r[0] <= PWDATA[11:0];
                RAPP_ADDR_VAGAIN_A + 8'h04: vagain_r[1] <= PWDATA[11:0];
                RAPP_ADDR_VAGAIN_A + 8'h08: vagain_r[2] <= PWDATA[11:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // per-phase power
    // ----------------------------------------------------------------
    always_comb begin
        rapp_phase_type ph [3];
        logic signed [59:0] sg;
        ph[0] = PH_A;
        ph[1] = PH_B;
        ph[2] = PH_C;
        sg = '0;
        for (int k = 0; k < 3; k++) begin
            // i_shift is already gain-corrected, hpf'd and -89 deg shifted
            q_inst[k] = smul(ph[k].v, ph[k].i_shift);
            p_ph[k] = 48'(ph[k].p_act);
            // rms offsets are trimmed upstream, none here
            s_ph[k] = ph[k].v_rms * ph[k].i_rms;
            sg = $signed({1'b0, s_ph[k]}) * $signed(vagain_r[k]);
            s_ph[k] = s_ph[k] + 48'(sg >>> RAPP_GAIN_SHIFT);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int k = 0; k < 3; k++) begin
                q_lpf_r[k] <= '0;
            end
        end else if (SAMPLE_VALID) begin
            // single-pole filter: ripple at 2x line freq traded for settle time
            for (int k = 0; k < 3; k++) begin
                q_lpf_r[k] <= q_lpf_r[k]
                    + ((q_inst[k] - q_lpf_r[k]) >>> RAPP_LPF_SHIFT);
            end
        end
    end

    // ----------------------------------------------------------------
    // phase combination
    // ----------------------------------------------------------------
    always_comb begin
        logic signed [47:0] t0;
        logic signed [47:0] t2;
        logic signed [47:0] qb;
        t0 = q_lpf_r[0];
        t2 = q_lpf_r[2];
        qb = '0;
        // delta forms approximated from per-phase dc terms
        unique case (comb)
            RAPP_COMB_STAR: qb = q_lpf_r[1];
            RAPP_COMB_DELTA: begin
                t0 = q_lpf_r[0] - q_lpf_r[1];
                t2 = q_lpf_r[2] - q_lpf_r[1];
            end
            RAPP_COMB_MIXED: t0 = q_lpf_r[0] - q_lpf_r[1];
            default: ;
        endcase
        qtot_nxt = (term_en[0] ? t0 : '0) + (term_en[1] ? qb : '0)
            + (term_en[2] ? t2 : '0);
        ptot_abs = (term_en[0] ? absv(p_ph[0]) : '0)
            + (term_en[1] ? absv(p_ph[1]) : '0)
            + (term_en[2] ? absv(p_ph[2]) : '0);
        stot_nxt = s_ph[0] + s_ph[1] + s_ph[2];
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            qtot_r <= '0;
            stot_r <= '0;
        end else begin
            // widened first so the product keeps its top bits
            qtot_r <= 48'((65'(qtot_nxt) * $signed({1'b0, RAPP_Q_SCALE}))
                >>> RAPP_Q_SCALE_SHIFT);
            stot_r <= stot_nxt;
        end
    end

    // ----------------------------------------------------------------
    // half-cycle counting
    // ----------------------------------------------------------------
    assign zx_hits = 2'(ZX_IN[0] & measurement_mode_reg_r[RAPP_ZX_LSB])
        + 2'(ZX_IN[1] & measurement_mode_reg_r[RAPP_ZX_LSB + 1])
        + 2'(ZX_IN[2] & measurement_mode_reg_r[RAPP_ZX_LSB + 2]);
    assign cycle_end = (zx_hits != 2'h0) && (32'(zx_cnt_r) + 32'(zx_hits) >= 32'(hcyc_r))
        && (hcyc_r != 16'h0000);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            zx_cnt_r <= '0;
        end else if (cycle_end) begin
            zx_cnt_r <= '0;
        end else begin
            zx_cnt_r <= zx_cnt_r + 16'(zx_hits);
        end
    end

    // ----------------------------------------------------------------
    // line accumulators
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lae_acc_r <= '0;
            lvae_acc_r <= '0;
            lae_hold_r <= '0;
            lvae_hold_r <= '0;
        end else if (cycle_end) begin
            lae_hold_r <= lae_acc_r;
            lvae_hold_r <= lvae_acc_r;
            lae_acc_r <= '0;
            lvae_acc_r <= '0;
        end else if (SAMPLE_VALID && (zx_cnt_r != 16'h0000 || zx_hits != 2'h0)) begin
            if (react_sel) begin
                lae_acc_r <= lae_acc_r + ACC_W'(qtot_r);
                lvae_acc_r <= lvae_acc_r + ACC_W'(ptot_abs);
            end else begin
                lae_acc_r <= lae_acc_r + ACC_W'(p_ph[0] + p_ph[1] + p_ph[2]);
                lvae_acc_r <= lvae_acc_r + ACC_W'(stot_r);
            end
        end
    end

    // ----------------------------------------------------------------
    // completion flag and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            done_flag_r <= 1'b0;
        end else if (cycle_end) begin
            done_flag_r <= 1'b1;
        end else if (wr && PADDR == RAPP_ADDR_IRQSTAT && PWDATA[RAPP_FLAG_DONE_BIT]) begin
            done_flag_r <= 1'b0;
        end
    end

    // open drain: only ever pulls low
    assign IRQ_N = 1'b0;
    assign IRQ_N_OE = done_flag_r && done_en_r;

    // ----------------------------------------------------------------
    // apb reads
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prdata_r <= '0;
        end else begin
            unique case (PADDR)
                RAPP_ADDR_WAVEFORM_MODE_CONTROL: prdata_r <= {24'h000000, wav_r};
                RAPP_ADDR_PWRSUM: prdata_r <= {24'h000000, pwrsum_r};
                RAPP_ADDR_MEASUREMENT_MODE_REG: prdata_r <= {24'h000000, measurement_mode_reg_r};
                RAPP_ADDR_HCYC: prdata_r <= {16'h0000, hcyc_r};
                RAPP_ADDR_IRQSTAT: prdata_r <= {31'h00000000, done_flag_r};
                RAPP_ADDR_IRQEN: prdata_r <= {31'h00000000, done_en_r};
                RAPP_ADDR_VAGAIN_A: prdata_r <= {20'h00000, vagain_r[0]};
                RAPP_ADDR_VAGAIN_A + 8'h04: prdata_r <= {20'h00000, vagain_r[1]};
                RAPP_ADDR_VAGAIN_A + 8'h08: prdata_r <= {20'h00000, vagain_r[2]};
                RAPP_ADDR_LAE: prdata_r <= 32'(lae_hold_r >>> 16);
                RAPP_ADDR_LVAE: prdata_r <= 32'(lvae_hold_r >> 16);
                RAPP_ADDR_QTOT: prdata_r <= qtot_r[47:16]; // sign is what matters
                RAPP_ADDR_STOT: prdata_r <= stot_r[47:16];
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign PRDATA = prdata_r;
    assign PSLVERR = 1'b0;

endmodule // rapp_path

// >>> hdl/rapp_pkg.sv
package rapp_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] RAPP_ADDR_WAVEFORM_MODE_CONTROL = 8'h0C;
    localparam logic [7:0] RAPP_ADDR_PWRSUM = 8'h10;
    localparam logic [7:0] RAPP_ADDR_MEASUREMENT_MODE_REG = 8'h14;
    localparam logic [7:0] RAPP_ADDR_HCYC = 8'h18;
    localparam logic [7:0] RAPP_ADDR_IRQSTAT = 8'h1C;
    localparam logic [7:0] RAPP_ADDR_IRQEN = 8'h20;
    localparam logic [7:0] RAPP_ADDR_VAGAIN_A = 8'h24;
    localparam logic [7:0] RAPP_ADDR_LAE = 8'h30;
    localparam logic [7:0] RAPP_ADDR_LVAE = 8'h34;
    localparam logic [7:0] RAPP_ADDR_QTOT = 8'h38;
    localparam logic [7:0] RAPP_ADDR_STOT = 8'h3C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int RAPP_WAV_REACT_BIT = 5;
    localparam int RAPP_COMB_LSB = 6;
    localparam int RAPP_TERM_LSB = 3;
    localparam int RAPP_ZX_LSB = 4;
    localparam int RAPP_FLAG_DONE_BIT = 0;
    localparam logic [7:0] RAPP_WAV_RST = 8'h00;
    localparam logic [7:0] RAPP_PWRSUM_RST = 8'h38;
    localparam logic [7:0] RAPP_MEASUREMENT_MODE_REG_RST = 8'h70;
    localparam logic [15:0] RAPP_HCYC_RST = 16'hFFFF;
    localparam logic [11:0] RAPP_VAGAIN_RST = 12'h000;
    localparam int RAPP_GAIN_SHIFT = 12;
    // reactive scale: 1/9.546 as Q16 (65536/9.546 = 6865)
    localparam logic [15:0] RAPP_Q_SCALE = 16'h1AD1;
    localparam int RAPP_Q_SCALE_SHIFT = 16;
    localparam int RAPP_LPF_SHIFT = 6;

    typedef enum logic [1:0] {
        RAPP_COMB_STAR = 2'h0,
        RAPP_COMB_DELTA = 2'h1,
        RAPP_COMB_MIXED = 2'h2
    } rapp_comb_type;

    typedef struct packed {
        logic signed [23:0] v;
        logic signed [23:0] i_shift;
        logic signed [23:0] p_act;
        logic [23:0] v_rms;
        logic [23:0] i_rms;
    } rapp_phase_type;

endpackage

// >>> tb/rapp_adc_model.sv
`timescale 1ns/10ps
module rapp_adc_model import rapp_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] zx_req,
    output logic sample_valid,
    output rapp_phase_type ph_a,
    output rapp_phase_type ph_b,
    output rapp_phase_type ph_c,
    output logic [2:0] zx_out
);
    // ------------------------------------------------------------
    // sample source: current already corrected, filtered, shifted
    // ------------------------------------------------------------
    logic [31:0] lfsr_r;
    logic [1:0] div_r;
    // new pseudo-random sample every fourth cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lfsr_r <= 32'h7D1C537A;
            div_r <= 2'h0;
            sample_valid <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            sample_valid <= (div_r == 2'h3);
            lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        end
    end
    // values change every cycle, never left holding a stale sample
    assign ph_a = {4{lfsr_r[29:0]}};
    assign ph_b = {4{lfsr_r[30:1]}};
    assign ph_c = {4{lfsr_r[31:2]}};
    // host reads reactive for sign only, energy by triangle
    // crossings are one-cycle pulses, only when the bench asks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zx_out <= 3'h0;
        end else begin
            zx_out <= zx_req;
        end
    end
endmodule // rapp_adc_model

// >>> tb/rapp_path_checker.sv
`timescale 1ns/10ps
module rapp_path_checker import rapp_pkg::*; (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [2:0] ZX_IN,
    input wire logic [2:0] ZX_DET_EN,
    input wire logic IRQ_N,
    input wire logic IRQ_N_OE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    logic wr_mm, wr_irq, rd_acc, zx_any;
    logic [2:0] mm_data;
    assign wr_mm = PSEL && PENABLE && PWRITE && PADDR == RAPP_ADDR_MEASUREMENT_MODE_REG;
    assign wr_irq = PSEL && PENABLE && PWRITE
        && (PADDR == RAPP_ADDR_IRQSTAT || PADDR == RAPP_ADDR_IRQEN);
    assign rd_acc = PSEL && PENABLE && !PWRITE;
    assign zx_any = |ZX_IN;
    assign mm_data = PWDATA[6:4];
    property p_irq_level; IRQ_N_OE |-> IRQ_N == 1'b0; endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq line not low");
    property p_det_hold; !$stable(ZX_DET_EN) |-> $past(wr_mm); endproperty
    a_det_hold: assert property (p_det_hold) else $error("detect enable moved");
    property p_det_val; wr_mm |=> ZX_DET_EN == $past(mm_data); endproperty
    a_det_val: assert property (p_det_val) else $error("detect enable value");
    property p_irq_clear; $fell(IRQ_N_OE) |-> $past(wr_irq); endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq dropped alone");
    property p_irq_masked;
        wr_irq && PADDR == RAPP_ADDR_IRQEN && !PWDATA[0] |=> !IRQ_N_OE;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq drives");
    property p_irq_cause;
        $rose(IRQ_N_OE) |-> $past(wr_irq) || $past(zx_any) || $past(zx_any, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_count_width; rd_acc && PADDR == RAPP_ADDR_HCYC |-> PRDATA[31:16] == 16'h0000; endproperty
    a_count_width: assert property (p_count_width) else $error("count too wide");
    property p_flag_width; rd_acc && PADDR == RAPP_ADDR_IRQSTAT |-> PRDATA[31:1] == 31'h0; endproperty
    a_flag_width: assert property (p_flag_width) else $error("status bits set");
endmodule // rapp_path_checker

bind rapp_path rapp_path_checker i_rapp_path_checker (.CLK(CLK), .ARST_N(ARST_N), .ZX_IN(ZX_IN),
    .ZX_DET_EN(ZX_DET_EN), .IRQ_N(IRQ_N), .IRQ_N_OE(IRQ_N_OE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA));

// >>> tb/rapp_path_tb_top.sv
`timescale 1ns/10ps
module rapp_path_tb_top import rapp_pkg::*;;
    // ------------------------------------------------------------
    // stimulus, queue monitor and verdict
    // ------------------------------------------------------------
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h7D1C537A;
    logic [2:0] zx_req = 3'h0, zx_in, zx_det_en;
    logic pready, pslverr, irq_n, irq_n_oe, sample_valid;
    rapp_phase_type ph_a, ph_b, ph_c;
    int failures = 0, comparisons = 0;
    logic [31:0] exp_q[$];
    logic [7:0] adr [6] = '{RAPP_ADDR_WAVEFORM_MODE_CONTROL, RAPP_ADDR_PWRSUM, RAPP_ADDR_MEASUREMENT_MODE_REG,
        RAPP_ADDR_HCYC, RAPP_ADDR_VAGAIN_A, RAPP_ADDR_IRQEN};
    logic [31:0] rst [6] = '{32'h0, 32'h38, 32'h70, 32'hFFFF, 32'h0, 32'h0};
    // gain kept below its sign bit: read-back extension is unspecified
    logic [31:0] msk [6] = '{32'hFF, 32'hB8, 32'h70, 32'hFFFF, 32'h7FF, 32'h1};
    always #5 clk = ~clk;
    rapp_adc_model i_rapp_adc_model (.clk(clk), .arst_n(arst_n), .zx_req(zx_req),
        .sample_valid(sample_valid), .ph_a(ph_a), .ph_b(ph_b), .ph_c(ph_c), .zx_out(zx_in));
    rapp_path i_rapp_path (.CLK(clk), .ARST_N(arst_n), .SAMPLE_VALID(sample_valid), .PH_A(ph_a),
        .PH_B(ph_b), .PH_C(ph_c), .ZX_IN(zx_in), .ZX_DET_EN(zx_det_en), .IRQ_N(irq_n),
        .IRQ_N_OE(irq_n_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic zx(logic [2:0] p, int n);
        repeat (n) begin
            zx_req <= p;
            @(posedge clk);
            zx_req <= 3'h0;
            repeat (9) @(posedge clk);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read data taken only at the completing access edge
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            check("pslverr", {31'h0, pslverr}, 32'h0);
            if (!pwrite) check("prdata", prdata, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        logic [31:0] v;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++) rd(adr[k], rst[k]);
        rd(RAPP_ADDR_IRQSTAT, 32'h0);
        for (int k = 0; k < 6; k++) begin
            v = rnd() & msk[k];
            apb(1'b1, adr[k], v);
            rd(adr[k], v);
        end
        apb(1'b1, RAPP_ADDR_VAGAIN_A, 32'h7FF);
        rd(RAPP_ADDR_VAGAIN_A, 32'h7FF);
        apb(1'b1, 8'h04, rnd());
        rd(8'h04, 32'h0);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, RAPP_ADDR_MEASUREMENT_MODE_REG, k << 4);
            check("zx_det_en", {29'h0, zx_det_en}, k);
        end
        apb(1'b1, RAPP_ADDR_PWRSUM, 32'h38);
        apb(1'b1, RAPP_ADDR_HCYC, 32'h3);
        apb(1'b1, RAPP_ADDR_IRQEN, 32'h1);
        apb(1'b1, RAPP_ADDR_MEASUREMENT_MODE_REG, 32'h10);
        zx(3'b110, 6);
        zx(3'b001, 2);
        rd(RAPP_ADDR_IRQSTAT, 32'h0);
        zx(3'b001, 2);
        rd(RAPP_ADDR_IRQSTAT, 32'h1);
        check("irq_n_oe", {31'h0, irq_n_oe}, 32'h1);
        check("irq_n", {31'h0, irq_n}, 32'h0);
        apb(1'b1, RAPP_ADDR_IRQSTAT, 32'h1);
        zx(3'b001, 1);
        rd(RAPP_ADDR_IRQSTAT, 32'h0);
        check("irq_n_oe", {31'h0, irq_n_oe}, 32'h0);
        apb(1'b1, RAPP_ADDR_IRQEN, 32'h0);
        zx(3'b001, 3);
        rd(RAPP_ADDR_IRQSTAT, 32'h1);
        check("irq_n_oe", {31'h0, irq_n_oe}, 32'h0);
        conclude();
    end
endmodule // rapp_path_tb_top
